//--- logic/gdeio_cell.sv
// I/O cell logic between core fabric and one bidirectional pad.
// Assumes launch/capture clocks are slow against clk and sampled here.
`default_nettype none
module gdeio_cell
    import gdeio_pkg::*;
#(
    parameter int FIFO_DEPTH = GDEIO_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_n,
    output logic pad_pull_up,
    output logic pad_pull_down,
    input wire logic launch_clock,
    input wire logic capture_clock,
    input wire logic in_reg_en,
    input wire logic out_reg_en,
    input wire logic oe_reg_en,
    input wire logic in_edge_sel,
    input wire logic out_edge_sel,
    input wire logic oe_edge_sel,
    input wire logic out_invert,
    input wire logic dual_edge_io_en,
    input wire logic resync_en,
    input wire logic pair_pad,
    input wire logic dual_capable,
    input wire logic pull_up_req,
    input wire logic pull_down_req,
    input wire logic [3:0] bypass_sel,
    output logic [1:0] core_in,
    input wire logic [1:0] core_out,
    input wire logic core_out_valid,
    output logic core_out_ready,
    input wire logic core_oe,
    output logic bypass_path,
    output logic global_clock_net,
    output logic global_control_net,
    output logic synth_reference_clock,
    output logic camera_link_ref_clock,
    output logic cfg_invalid
);
    logic [GDEIO_SYNC_W-1:0] sync_q;
    logic pad_s;
    logic launch_s;
    logic capture_s;
    logic launch_prev;
    logic capture_prev;
    logic launch_rise;
    logic launch_fall;
    logic cap_rise;
    logic cap_fall;
    logic cap_sel_edge;
    logic launch_sel_edge;
    logic oe_sel_edge;
    logic dual_eff;
    logic resync_eff;
    logic out_pop;
    logic inv_en;
    logic fall_hold;
    logic [1:0] cur_word;
    logic [1:0] stage_word;

    gdeio_stream_if #(.W(GDEIO_WORD_W)) os ();

    gdeio_sync #(.W(GDEIO_SYNC_W)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .d({capture_clock, launch_clock, pad_in}),
        .q(sync_q)
    );

    gdeio_fifo #(.W(GDEIO_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .s(os)
    );

    assign pad_s = sync_q[GDEIO_SYNC_PAD];
    assign launch_s = sync_q[GDEIO_SYNC_LAUNCH];
    assign capture_s = sync_q[GDEIO_SYNC_CAPTURE];
    assign launch_rise = launch_s && !launch_prev;
    assign launch_fall = !launch_s && launch_prev;
    assign cap_rise = capture_s && !capture_prev;
    assign cap_fall = !capture_s && capture_prev;
    // Per-register edge choice
    assign cap_sel_edge = (in_edge_sel == GDEIO_EDGE_FALL) ? cap_fall
        : cap_rise;
    assign launch_sel_edge = (out_edge_sel == GDEIO_EDGE_FALL) ? launch_fall
        : launch_rise;
    assign oe_sel_edge = (oe_edge_sel == GDEIO_EDGE_FALL) ? launch_fall
        : launch_rise;
    // Dual edge only on capable single-ended pads
    assign dual_eff = dual_edge_io_en && dual_capable
        && !pair_pad;
    assign resync_eff = dual_eff && resync_en;
    assign inv_en = out_invert && (out_reg_en || dual_eff);

    // Core write side and launch-side pop
    assign os.wr_valid = core_out_valid;
    assign os.wr_data = core_out;
    assign core_out_ready = os.wr_ready;
    assign out_pop = dual_eff ? launch_rise
        : (out_reg_en ? launch_sel_edge : 1'b1);
    assign os.rd_ready = out_pop;

    // Combinational bypass from the raw pad
    assign bypass_path = !in_reg_en && !out_reg_en && !dual_eff
        && pad_in;
    assign global_clock_net = bypass_path && bypass_sel[0];
    assign global_control_net = bypass_path && bypass_sel[1];
    assign synth_reference_clock = bypass_path && bypass_sel[2];
    assign camera_link_ref_clock = bypass_path && bypass_sel[3];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            launch_prev <= 1'b0;
            capture_prev <= 1'b0;
        end else if (clk_en) begin
            launch_prev <= launch_s;
            capture_prev <= capture_s;
        end
    end

    // Input path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            core_in <= GDEIO_CORE_IN_RST;
            fall_hold <= 1'b0;
        end else if (clk_en) begin
            if (resync_eff) begin
                if (cap_fall) begin
                    fall_hold <= pad_s;
                end
                if (cap_rise) begin
                    core_in <= {fall_hold, pad_s};
                end
            end else if (dual_eff) begin
                if (cap_rise) begin
                    core_in[GDEIO_RISING_SLOT] <= pad_s;
                end
                if (cap_fall) begin
                    core_in[GDEIO_FALLING_SLOT] <= pad_s;
                end
            end else if (in_reg_en) begin
                if (cap_sel_edge) begin
                    core_in <= {1'b0, pad_s};
                end
            end else begin
                core_in <= {1'b0, pad_s};
            end
        end
    end

    // Output data path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_out <= GDEIO_PAD_OUT_RST;
            cur_word <= GDEIO_WORD_RST;
            stage_word <= GDEIO_WORD_RST;
        end else if (clk_en) begin
            if (resync_eff) begin
                if (launch_rise) begin
                    if (os.rd_valid) begin
                        stage_word <= os.rd_data;
                    end
                    cur_word <= stage_word;
                    pad_out <= stage_word[GDEIO_RISING_SLOT] ^ inv_en;
                end
                if (launch_fall) begin
                    pad_out <= cur_word[GDEIO_FALLING_SLOT] ^ inv_en;
                end
            end else if (dual_eff) begin
                if (launch_rise && os.rd_valid) begin
                    cur_word <= os.rd_data;
                    pad_out <= os.rd_data[GDEIO_RISING_SLOT]
                        ^ inv_en;
                end
                if (launch_fall) begin
                    pad_out <= cur_word[GDEIO_FALLING_SLOT]
                        ^ inv_en;
                end
            end else if (out_pop && os.rd_valid) begin
                pad_out <= os.rd_data[GDEIO_RISING_SLOT]
                    ^ inv_en;
            end
        end
    end

    // Drive enable, low-active pad enable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_oe_n <= GDEIO_PAD_OE_N_RST;
        end else if (clk_en) begin
            if (!oe_reg_en || oe_sel_edge) begin
                pad_oe_n <= !core_oe;
            end
        end
    end

    // Pulls and configuration check
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pad_pull_up <= GDEIO_PULL_UP_RST;
            pad_pull_down <= GDEIO_PULL_DOWN_RST;
            cfg_invalid <= 1'b0;
        end else if (clk_en) begin
            pad_pull_up <= pull_up_req;
            pad_pull_down <= pull_down_req && !pair_pad;
            cfg_invalid <= (dual_edge_io_en && (!dual_capable || pair_pad))
                || (pull_down_req && pair_pad);
        end
    end

    property p_single_in;
        @(posedge clk) disable iff (!reset_n)
        $past(clk_en && !dual_eff && in_reg_en && cap_sel_edge)
            |-> core_in[0] == $past(pad_s);
    endproperty
    a_single_in: assert property (p_single_in)
        else $error("single edge capture wrong");
    property p_dual_fall_in;
        @(posedge clk) disable iff (!reset_n)
        $past(clk_en && dual_eff && !resync_en && cap_fall)
            |-> core_in[1] == $past(pad_s);
    endproperty
    a_dual_fall_in: assert property (p_dual_fall_in)
        else $error("falling sample not on bit 1");
    property p_resync_pair;
        @(posedge clk) disable iff (!reset_n)
        $past(clk_en && resync_eff && cap_rise)
            |-> core_in == {$past(fall_hold), $past(pad_s)};
    endproperty
    a_resync_pair: assert property (p_resync_pair)
        else $error("resync pair misaligned");
    property p_resync_steady;
        @(posedge clk) disable iff (!reset_n)
        $past(clk_en && resync_eff && !cap_rise)
            |-> core_in == $past(core_in);
    endproperty
    a_resync_steady: assert property (p_resync_steady)
        else $error("resync changed off rising edge");
    property p_invalid;
        @(posedge clk) disable iff (!reset_n)
        $past(clk_en && dual_edge_io_en && (!dual_capable || pair_pad))
            |-> cfg_invalid && !$past(dual_eff);
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("bad dual request not flagged");
    property p_pull_down;
        @(posedge clk) disable iff (!reset_n)
        $past(clk_en && pair_pad) |-> !pad_pull_down;
    endproperty
    a_pull_down: assert property (p_pull_down)
        else $error("pull-down on pair pad");
    property p_oe_hold;
        @(posedge clk) disable iff (!reset_n)
        $past(clk_en && oe_reg_en && !oe_sel_edge)
            |-> pad_oe_n == $past(pad_oe_n);
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("enable register moved off edge");
    property p_oe_follow;
        @(posedge clk) disable iff (!reset_n)
        $past(clk_en && !oe_reg_en) |-> pad_oe_n == !$past(core_oe);
    endproperty
    a_oe_follow: assert property (p_oe_follow)
        else $error("driver enable wrong");

    property p_bypass;
        @(posedge clk) disable iff (!reset_n)
        (!in_reg_en && !out_reg_en && !dual_eff) |-> bypass_path == pad_in;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass not combinational");

    property p_out_reg;
        @(posedge clk) disable iff (!reset_n)
        $past(clk_en && out_reg_en && !dual_eff && launch_sel_edge
            && os.rd_valid)
            |-> pad_out == ($past(os.rd_data[0]) ^ $past(out_invert));
    endproperty
    a_out_reg: assert property (p_out_reg)
        else $error("registered output value wrong");

    property p_dual_out_fall;
        @(posedge clk) disable iff (!reset_n)
        $past(clk_en && dual_eff && launch_fall)
            |-> pad_out == ($past(cur_word[1]) ^ $past(out_invert));
    endproperty
    a_dual_out_fall: assert property (p_dual_out_fall)
        else $error("falling slot not launched");

    property p_c_resync;
        @(posedge clk) disable iff (!reset_n)
        clk_en && resync_eff && cap_rise;
    endproperty
    c_resync: cover property (p_c_resync);
    property p_c_dual_out;
        @(posedge clk) disable iff (!reset_n)
        clk_en && dual_eff && launch_fall ##[1:50] launch_rise;
    endproperty
    c_dual_out: cover property (p_c_dual_out);
    property p_c_full;
        @(posedge clk) disable iff (!reset_n)
        core_out_valid && !core_out_ready;
    endproperty
    c_full: cover property (p_c_full);
    property p_c_bypass;
        @(posedge clk) disable iff (!reset_n)
        bypass_path && bypass_sel[2];
    endproperty
    c_bypass: cover property (p_c_bypass);
endmodule // gdeio_cell
`default_nettype wire

//--- logic/gdeio_pkg.sv
// Constants shared by the dual-edge I/O cell and its helpers.
// Assumes one system clock; launch and capture clocks arrive as inputs.
`default_nettype none
package gdeio_pkg;
    localparam int GDEIO_FIFO_DEPTH = 4;
    localparam int GDEIO_WORD_W = 2;
    localparam int GDEIO_SYNC_W = 3;
    localparam int GDEIO_SYNC_PAD = 0;
    localparam int GDEIO_SYNC_LAUNCH = 1;
    localparam int GDEIO_SYNC_CAPTURE = 2;
    localparam int GDEIO_RISING_SLOT = 0;
    localparam int GDEIO_FALLING_SLOT = 1;
    localparam logic GDEIO_EDGE_RISE = 1'h0;
    localparam logic GDEIO_EDGE_FALL = 1'h1;
    localparam logic [1:0] GDEIO_CORE_IN_RST = 2'h0;
    localparam logic [1:0] GDEIO_WORD_RST = 2'h0;
    localparam logic [2:0] GDEIO_SYNC_RST = 3'h0;
    localparam logic GDEIO_PAD_OUT_RST = 1'h0;
    localparam logic GDEIO_PAD_OE_N_RST = 1'h1;
    localparam logic GDEIO_PULL_UP_RST = 1'h1;
    localparam logic GDEIO_PULL_DOWN_RST = 1'h0;
endpackage
`default_nettype wire

//--- logic/gdeio_stream_if.sv
// Valid/ready word stream between the cell and its FIFO.
// Assumes both ends run on the same clock.
`default_nettype none
interface gdeio_stream_if #(parameter int W = 2) ();
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    modport fifo (
        input wr_valid, wr_data, rd_ready,
        output wr_ready, rd_valid, rd_data
    );
    modport user (
        output wr_valid, wr_data, rd_ready,
        input wr_ready, rd_valid, rd_data
    );
endinterface
`default_nettype wire

//--- logic/gdeio_fifo.sv
// Small word FIFO with honest full and empty.
// Assumes the stream interface width matches W.
`default_nettype none
module gdeio_fifo
    import gdeio_pkg::*;
#(
    parameter int W = GDEIO_WORD_W,
    parameter int DEPTH = GDEIO_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    gdeio_stream_if.fifo s
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign push = s.wr_valid && s.wr_ready;
    assign pop = s.rd_valid && s.rd_ready;
    assign s.wr_ready = (count != FULL);
    assign s.rd_valid = (count != '0);
    assign s.rd_data = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem[wr_ptr] <= s.wr_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (clk_en) begin
            case ({push, pop})
                2'h2: count <= count + 1'b1;
                2'h1: count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end
endmodule // gdeio_fifo
`default_nettype wire

//--- logic/gdeio_sync.sv
// Three-stage synchroniser; output moves once stages two and three agree.
// Assumes inputs are asynchronous to clk.
`default_nettype none
module gdeio_sync
    import gdeio_pkg::*;
#(
    parameter int W = GDEIO_SYNC_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
            q <= '0;
        end else if (clk_en) begin
            ff1 <= d;
            ff2 <= ff1;
            ff3 <= ff2;
            for (int i = 0; i < W; i++) begin
                if (ff2[i] == ff3[i]) begin
                    q[i] <= ff3[i];
                end
            end
        end
    end
endmodule // gdeio_sync
`default_nettype wire

//--- testbench/gdeio_core_model.sv
// Core-side model: sends words into the cell, steers drive enable.
// Assumes calls arrive 1 ns after a rising edge of clk.
`default_nettype none
module gdeio_core_model
    import gdeio_pkg::*;
(
    input wire logic clk,
    input wire logic core_out_ready,
    output var logic [1:0] core_out,
    output var logic core_out_valid,
    output var logic core_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap = 0;
    initial begin
        core_out = 2'h0;
        core_out_valid = 1'b0;
        core_oe = 1'b0;
    end
    // Word held until taken, then shown inverted
    task automatic send(input logic [1:0] w);
        repeat (gap + 1) begin
            @(posedge clk);
            #1;
        end
        core_out_valid = 1'b1;
        core_out = w;
        do @(negedge clk); while (!core_out_ready);
        @(posedge clk);
        #1;
        core_out_valid = 1'b0;
        core_out = ~w;
    endtask
    task automatic drive(input logic v);
        core_oe = v;
    endtask
endmodule // gdeio_core_model
`default_nettype wire

//--- testbench/gdeio_cell_test.sv
// Bench for the dual-edge I/O cell: random and corner traffic.
// Assumes the core model and the cell's design files.
`default_nettype none
module gdeio_cell_test
    import gdeio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic in_reg, out_reg, oe_reg, in_fall, out_fall, oe_fall;
        logic inv, dual, resync, pair, able, pu, pd;
    } gdeio_cfg_t;
    gdeio_cfg_t c = '0;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic pad_ext = 1'b1;
    logic launch_clock = 1'b0;
    logic capture_clock = 1'b0;
    logic [3:0] bypass_sel = 4'h0;
    logic [31:0] seed = 32'h00015DFE;
    logic [1:0] w = 2'h0;
    logic [1:0] prev, x;
    logic [1:0] q [4];
    logic a, b;
    int n_mismatch = 0;
    int checks_done = 0;
    logic pad_out, pad_oe_n, pad_pull_up, pad_pull_down, core_out_valid;
    logic core_out_ready, core_oe, bypass_path, cfg_invalid;
    logic [1:0] core_in, core_out;
    wire logic [3:0] nets;
    wire logic pad_in = pad_oe_n ? pad_ext : pad_out;

    always #2 clk = ~clk;

    gdeio_cell u_gdeio_cell (
        .clk, .reset_n, .clk_en, .pad_in, .pad_out, .pad_oe_n,
        .pad_pull_up, .pad_pull_down, .launch_clock, .capture_clock,
        .in_reg_en(c.in_reg), .out_reg_en(c.out_reg),
        .oe_reg_en(c.oe_reg), .in_edge_sel(c.in_fall),
        .out_edge_sel(c.out_fall), .oe_edge_sel(c.oe_fall),
        .out_invert(c.inv), .dual_edge_io_en(c.dual),
        .resync_en(c.resync), .pair_pad(c.pair), .dual_capable(c.able),
        .pull_up_req(c.pu), .pull_down_req(c.pd), .bypass_sel,
        .core_in, .core_out, .core_out_valid, .core_out_ready, .core_oe,
        .bypass_path, .global_clock_net(nets[0]),
        .global_control_net(nets[1]), .synth_reference_clock(nets[2]),
        .camera_link_ref_clock(nets[3]), .cfg_invalid
    );
    gdeio_core_model u_gdeio_core_model (
        .clk, .core_out_ready, .core_out, .core_out_valid, .core_oe
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic exp_inv(input gdeio_cfg_t k);
        return (k.dual & (!k.able | k.pair)) | (k.pd & k.pair);
    endfunction
    task automatic check(input string what, input logic [3:0] seen,
                         input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic lc();
        launch_clock = ~launch_clock;
        step(12);
    endtask
    task automatic cc();
        capture_clock = ~capture_clock;
        step(12);
    endtask
    task automatic note(input string n);
        $display("test %s done", n);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #40000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge clk);
        #1;
        check("oe_n in reset", pad_oe_n, GDEIO_PAD_OE_N_RST);
        check("ready in reset", core_out_ready, 1'b1);
        reset_n = 1'b1;
        step(6);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            pad_ext = seed[0];
            bypass_sel = seed[4:1];
            #1;
            check("bypass", bypass_path, pad_ext);
            check("nets", nets, bypass_sel & {4{pad_ext}});
            step(8);
            check("core_in", core_in, {1'b0, pad_ext});
        end
        c.in_reg = 1'b1;
        pad_ext = 1'b1;
        step(8);
        check("bypass gated", bypass_path, 1'b0);
        note("bypass");
        for (int k = 0; k < 16; k++) begin
            seed = xs(seed);
            c = '0;
            {c.dual, c.able, c.pair, c.pd} = k[3:0];
            c.pu = seed[0];
            step(2);
            check("pull_down", pad_pull_down, c.pd & !c.pair);
            check("pull_up", pad_pull_up, c.pu);
            check("invalid", cfg_invalid, exp_inv(c));
        end
        c = '0;
        note("config");
        u_gdeio_core_model.drive(1'b1);
        step(4);
        check("oe_n on", pad_oe_n, 1'b0);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            u_gdeio_core_model.gap = seed[3:2];
            u_gdeio_core_model.send(seed[1:0]);
            step(10);
            check("pad single", pad_out, seed[0]);
            check("pad loop", core_in, {1'b0, seed[0]});
        end
        u_gdeio_core_model.drive(1'b0);
        pad_ext = ~seed[0];
        step(10);
        check("oe_n off", pad_oe_n, 1'b1);
        check("pad heard", core_in, {1'b0, pad_ext});
        note("single out");
        c.out_reg = 1'b1;
        c.out_fall = 1'b1;
        c.inv = 1'b1;
        b = seed[0];
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            q[i] = seed[1:0];
            u_gdeio_core_model.send(q[i]);
        end
        step(1);
        check("full", core_out_ready, 1'b0);
        for (int i = 0; i < 4; i++) begin
            lc();
            check("no pop on rise", pad_out, b);
            lc();
            b = q[i][0] ^ 1'b1;
            check("pop on fall", pad_out, b);
        end
        check("drained", core_out_ready, 1'b1);
        note("fifo");
        c = '0;
        c.dual = 1'b1;
        c.able = 1'b1;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            c.resync = i[2];
            prev = w;
            w = seed[1:0];
            u_gdeio_core_model.send(w);
            x = c.resync ? prev : w;
            lc();
            if (i != 4) check("dual rise", pad_out, x[0]);
            lc();
            if (i != 4) check("dual fall", pad_out, x[1]);
        end
        note("dual out");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            c.resync = i[2];
            a = seed[0];
            pad_ext = a;
            step(8);
            cc();
            if (c.resync && i != 4)
                check("resync pair", core_in, {b, a});
            else
                check("rise slot", core_in[0], a);
            pad_ext = seed[1];
            step(8);
            cc();
            if (!c.resync)
                check("fall slot", core_in, {pad_ext, a});
            else if (i != 4)
                check("resync hold", core_in, {b, a});
            b = pad_ext;
        end
        note("dual in");
        c = '0;
        c.oe_reg = 1'b1;
        u_gdeio_core_model.drive(1'b1);
        step(10);
        check("oe waits", pad_oe_n, 1'b1);
        lc();
        check("oe on launch", pad_oe_n, 1'b0);
        note("enable");
        c.oe_reg = 1'b0;
        clk_en = 1'b0;
        u_gdeio_core_model.drive(1'b0);
        step(6);
        check("frozen", pad_oe_n, 1'b0);
        clk_en = 1'b1;
        step(2);
        check("thawed", pad_oe_n, 1'b1);
        note("freeze");
        end_of_test();
    end
endmodule // gdeio_cell_test
`default_nettype wire
